// ---- common/bpr_pkg.sv ----
package bpr_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_IFS    = 8'h08;
	localparam logic [7:0] OFF_RXPCB  = 8'h0C;
	localparam logic [7:0] OFF_RXLEN  = 8'h10;
	localparam logic [7:0] OFF_TXPCB  = 8'h14;
	localparam logic [7:0] OFF_TXLEN  = 8'h18;
	localparam logic [7:0] OFF_CMD    = 8'h1C;
	// pcb coding
	localparam logic [2:0] R_TAG      = 3'h4;
	localparam logic [1:0] S_TAG      = 2'h3;
	localparam logic [3:0] R_OK       = 4'h0;
	localparam logic [3:0] R_EDC      = 4'h1;
	localparam logic [3:0] R_OTHER    = 4'h2;
	localparam logic [4:0] S_RESYNCH  = 5'h00;
	localparam logic [4:0] S_IFS      = 5'h01;
	localparam logic [4:0] S_ABORT    = 5'h02;
	localparam logic [4:0] S_WTX      = 5'h03;
	localparam logic [7:0] LEN_RFU    = 8'hFF;
	localparam logic [7:0] IFS_RESET  = 8'h20;
	localparam logic [1:0] MAX_RETRY  = 2'h2;
	localparam logic [1:0] IFS_RETRY  = 2'h1;
	// command codes written to the command register
	localparam logic [1:0] CMD_IBLK   = 2'h1;
	localparam logic [1:0] CMD_IFSREQ = 2'h2;
	localparam logic [1:0] CMD_ABORT  = 2'h3;
	typedef enum logic [1:0] {
		K_NONE, K_I, K_R, K_S
	} bpr_kind_t;
	typedef struct packed {
		logic [7:0] pcb;
		logic [7:0] len;
	} bpr_hdr_t;
endpackage : bpr_pkg

// ---- src/bpr_top.sv ----
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module bpr_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        rx_done,
	input  wire logic [7:0]  rx_pcb,
	input  wire logic [7:0]  rx_len,
	input  wire logic        rx_parity_err,
	input  wire logic        rx_lrc_err,
	input  wire logic        rx_sync_lost,
	input  wire logic        bwt_expired,
	output logic             tx_start,
	output logic [7:0]       tx_pcb,
	output logic [7:0]       tx_len
);
	typedef enum {ST_IDLE, ST_WAIT} bpr_state_t;
	bpr_state_t     state_reg;
	bpr_pkg::bpr_hdr_t last_reg;
	logic [7:0]     ifsc_reg;
	logic [7:0]     ifsd_reg;
	logic           ns_reg;
	logic           nr_reg;
	logic           first_reg;
	logic           rx_chain_reg;
	logic [1:0]     retry_reg;
	logic           mute_reg;
	logic           err_reg;
	logic           aw_hold;
	logic           w_hold;
	logic [7:0]     aw_addr;
	logic [31:0]    w_data;
	logic [1:0]     cmd_next;
	logic [7:0]     cmd_len;
	logic           cmd_more;
	logic           rx_invalid;
	bpr_pkg::bpr_kind_t kind;

	function automatic bpr_pkg::bpr_kind_t kind_of(input logic [7:0] p);
		if (!p[7])
			return bpr_pkg::K_I;
		if (p[7:5] == bpr_pkg::R_TAG)
			return bpr_pkg::K_R;
		if (p[7:6] == bpr_pkg::S_TAG)
			return bpr_pkg::K_S;
		return bpr_pkg::K_NONE;
	endfunction : kind_of

	function automatic logic [7:0] r_pcb(input logic n, input logic [3:0] e);
		return {bpr_pkg::R_TAG, n, e};
	endfunction : r_pcb

	// synchronise the link strobes
	logic [1:0] done_sy, bwt_sy;
	logic       done_q, bwt_q, done_p, bwt_p;
	always_ff @(posedge aclk) begin
		done_sy <= {done_sy[0], rx_done};
		bwt_sy  <= {bwt_sy[0], bwt_expired};
		done_q  <= done_sy[1];
		bwt_q   <= bwt_sy[1];
	end
	assign done_p = done_sy[1] & ~done_q;
	assign bwt_p  = bwt_sy[1] & ~bwt_q;

	assign kind = kind_of(rx_pcb);
	always_comb begin
		rx_invalid = rx_parity_err | rx_lrc_err | rx_sync_lost
			| (kind == bpr_pkg::K_NONE) | (rx_len == bpr_pkg::LEN_RFU);
		// mid-chain only I-blocks; S requests still pass
		// so that abort and resynch can break into a chain
		if (rx_chain_reg && kind != bpr_pkg::K_I
			&& !(kind == bpr_pkg::K_S && !rx_pcb[5]))
			rx_invalid = 1'b1;
		// while waiting on an S request, reply must be the matching response
		if (state_reg == ST_WAIT && last_reg.pcb[7:6] == bpr_pkg::S_TAG
			&& !last_reg.pcb[5] && rx_pcb != (last_reg.pcb | 8'h20))
			rx_invalid = 1'b1;
	end

	// axi write: address and data in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold <= 1'b0;
			w_hold  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
			end
			if (aw_hold && w_hold) begin
				aw_hold <= 1'b0;
				w_hold  <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
	assign s_axi_bresp   = 2'h0;
	logic wr_go;
	assign wr_go = aw_hold & w_hold;

	// host commands; ignored while a block is outstanding
	always_comb begin
		cmd_next = 2'h0;
		cmd_len  = w_data[15:8];
		cmd_more = w_data[16];
		if (wr_go && aw_addr == bpr_pkg::OFF_CMD && state_reg == ST_IDLE
			&& !mute_reg)
			cmd_next = w_data[1:0];
	end

	// axi read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			case (s_axi_araddr)
				bpr_pkg::OFF_STATUS: s_axi_rdata <= {24'h0, err_reg, mute_reg,
					retry_reg, rx_chain_reg, nr_reg, ns_reg,
					state_reg == ST_WAIT};
				bpr_pkg::OFF_IFS:   s_axi_rdata <= {16'h0, ifsd_reg, ifsc_reg};
				bpr_pkg::OFF_RXPCB: s_axi_rdata <= {24'h0, rx_pcb};
				bpr_pkg::OFF_RXLEN: s_axi_rdata <= {24'h0, rx_len};
				bpr_pkg::OFF_TXPCB: s_axi_rdata <= {24'h0, last_reg.pcb};
				bpr_pkg::OFF_TXLEN: s_axi_rdata <= {24'h0, last_reg.len};
				default:            s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
	assign s_axi_arready = ~s_axi_rvalid;
	assign s_axi_rresp   = 2'h0;

	// ifs sizes; ifsd renewed on terminal ifs request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ifsc_reg <= bpr_pkg::IFS_RESET;
			ifsd_reg <= bpr_pkg::IFS_RESET;
		end else begin
			if (wr_go && aw_addr == bpr_pkg::OFF_IFS)
				ifsc_reg <= w_data[7:0];
			if (done_p && !rx_invalid && kind == bpr_pkg::K_S
				&& rx_pcb[4:0] == bpr_pkg::S_IFS && !rx_pcb[5])
				ifsd_reg <= w_data[15:8];
		end
	end

	// protocol engine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_IDLE;
			last_reg  <= '0;
			ns_reg <= 1'b0;
			nr_reg <= 1'b0;
			first_reg <= 1'b1;
			rx_chain_reg <= 1'b0;
			retry_reg <= 2'h0;
			mute_reg <= 1'b0;
			err_reg <= 1'b0;
			tx_start <= 1'b0;
			tx_pcb <= 8'h00;
			tx_len <= 8'h00;
		end else begin
			tx_start <= 1'b0;
			if (cmd_next == bpr_pkg::CMD_IBLK) begin
				tx_pcb <= {1'b0, ns_reg, cmd_more, 5'h00};
				// zero length passes, host should avoid it
				tx_len <= (cmd_len > ifsd_reg) ? ifsd_reg : cmd_len;
				last_reg <= '{pcb: {1'b0, ns_reg, cmd_more, 5'h00},
					len: (cmd_len > ifsd_reg) ? ifsd_reg : cmd_len};
				tx_start <= 1'b1;
				// card spoke first, so its reply is no opening block
				first_reg <= 1'b0;
				state_reg <= ST_WAIT;
				retry_reg <= 2'h0;
			end else if (cmd_next == bpr_pkg::CMD_IFSREQ
				|| cmd_next == bpr_pkg::CMD_ABORT) begin
				tx_pcb <= {bpr_pkg::S_TAG, 1'b0,
					cmd_next == bpr_pkg::CMD_ABORT ? bpr_pkg::S_ABORT
					: bpr_pkg::S_IFS};
				last_reg.pcb <= {bpr_pkg::S_TAG, 1'b0,
					cmd_next == bpr_pkg::CMD_ABORT ? bpr_pkg::S_ABORT
					: bpr_pkg::S_IFS};
				tx_len <= 8'h00;
				last_reg.len <= 8'h00;
				tx_start <= 1'b1;
				first_reg <= 1'b0;
				state_reg <= ST_WAIT;
				retry_reg <= 2'h0;
			end else if (!mute_reg && ((done_p && rx_invalid)
				|| (bwt_p && state_reg == ST_WAIT))) begin
				err_reg <= 1'b1;
				tx_start <= 1'b1;
				retry_reg <= retry_reg + 2'h1;
				first_reg <= 1'b0;
				tx_len <= 8'h00;
				if (first_reg)
					tx_pcb <= r_pcb(1'b0, rx_lrc_err | rx_parity_err
						? bpr_pkg::R_EDC : bpr_pkg::R_OTHER);
				// ifs request retried once, then dropped back to idle without muting
				else if (last_reg.pcb == {bpr_pkg::S_TAG, 1'b0, bpr_pkg::S_IFS}
					&& retry_reg >= bpr_pkg::IFS_RETRY) begin
					tx_start <= 1'b0;
					state_reg <= ST_IDLE;
				end
				else if (retry_reg >= bpr_pkg::MAX_RETRY) begin
					tx_start <= 1'b0;
					mute_reg <= 1'b1;
				end
				else if (last_reg.pcb[7:5] == {bpr_pkg::S_TAG, 1'b0})
					tx_pcb <= last_reg.pcb;
				else if (last_reg.pcb[7:5] == bpr_pkg::R_TAG)
					tx_pcb <= last_reg.pcb;
				else
					tx_pcb <= r_pcb(nr_reg, rx_lrc_err | rx_parity_err
						? bpr_pkg::R_EDC : bpr_pkg::R_OTHER);
			// a mute card ignores every block except an ifs request, which still renews ifsd
			end else if (done_p && !mute_reg) begin
				first_reg <= 1'b0;
				retry_reg <= 2'h0;
				err_reg <= 1'b0;
				tx_len <= 8'h00;
				// ack of own i-block toggles send counter
				if (last_reg.pcb[7] == 1'b0 && kind != bpr_pkg::K_S
					&& rx_pcb[kind == bpr_pkg::K_I ? 6 : 4] != ns_reg)
					ns_reg <= ~ns_reg;
				if (kind == bpr_pkg::K_I && rx_len > ifsc_reg) begin
					tx_pcb <= r_pcb(nr_reg, bpr_pkg::R_OTHER);
					last_reg.pcb <= r_pcb(nr_reg, bpr_pkg::R_OTHER);
					tx_start <= 1'b1;
				end else if (kind == bpr_pkg::K_I) begin
					nr_reg <= ~rx_pcb[6];
					rx_chain_reg <= rx_pcb[5];
					state_reg <= ST_IDLE;
					if (rx_pcb[5]) begin
						tx_pcb <= r_pcb(~rx_pcb[6], bpr_pkg::R_OK);
						last_reg.pcb <= r_pcb(~rx_pcb[6], bpr_pkg::R_OK);
						tx_start <= 1'b1;
					end
				end else if (kind == bpr_pkg::K_S && !rx_pcb[5]) begin
					tx_pcb <= rx_pcb | 8'h20;
					last_reg.pcb <= rx_pcb | 8'h20;
					tx_len <= rx_len;
					tx_start <= 1'b1;
					if (rx_pcb[4:0] == bpr_pkg::S_ABORT)
						rx_chain_reg <= 1'b0;
					if (rx_pcb[4:0] == bpr_pkg::S_RESYNCH) begin
						ns_reg <= 1'b0;
						nr_reg <= 1'b0;
						rx_chain_reg <= 1'b0;
					end
				end else
					state_reg <= ST_IDLE;
			end
		end
	end

	chk_ovr_reject: assert property (@(posedge aclk) disable iff (!aresetn)
		done_p && !rx_invalid && !mute_reg && cmd_next == 2'h0
		&& kind == bpr_pkg::K_I && rx_len > ifsc_reg
		|=> tx_start && tx_pcb[3:0] == bpr_pkg::R_OTHER)
		else $error("oversize block not rejected");
	chk_chain_ack: assert property (@(posedge aclk) disable iff (!aresetn)
		done_p && !rx_invalid && !mute_reg && cmd_next == 2'h0
		&& kind == bpr_pkg::K_I && rx_pcb[5] && rx_len <= ifsc_reg
		|=> tx_start && tx_pcb[7:5] == bpr_pkg::R_TAG
		&& tx_pcb[4] == ~$past(rx_pcb[6]))
		else $error("chained block not acknowledged");
	chk_mute_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		mute_reg |-> !tx_start)
		else $error("muted card transmitted");
	chk_r_resend: assert property (@(posedge aclk) disable iff (!aresetn)
		((done_p && rx_invalid) || (bwt_p && state_reg == ST_WAIT))
		&& !mute_reg && !first_reg
		&& cmd_next == 2'h0 && retry_reg < bpr_pkg::MAX_RETRY
		&& last_reg.pcb[7:5] == bpr_pkg::R_TAG
		|=> tx_start && tx_pcb == $past(last_reg.pcb))
		else $error("r-block not resent");
	chk_first_r0: assert property (@(posedge aclk) disable iff (!aresetn)
		done_p && rx_invalid && first_reg && !mute_reg && cmd_next == 2'h0
		|=> tx_start && tx_pcb[7:4] == {bpr_pkg::R_TAG, 1'b0})
		else $error("first bad block not answered r0");
	chk_i_len: assert property (@(posedge aclk) disable iff (!aresetn)
		tx_start && !tx_pcb[7] |-> tx_len <= ifsd_reg)
		else $error("i-block longer than ifsd");
	chk_s_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		done_p && !rx_invalid && !mute_reg && cmd_next == 2'h0
		&& kind == bpr_pkg::K_S && !rx_pcb[5]
		|=> tx_start && tx_pcb[5] && tx_pcb[7:6] == bpr_pkg::S_TAG)
		else $error("s request unanswered");
	chk_bad_pcb: assert property (@(posedge aclk) disable iff (!aresetn)
		done_p && kind == bpr_pkg::K_NONE && !mute_reg && cmd_next == 2'h0
		|=> err_reg)
		else $error("bad pcb accepted");
	cov_chain: cover property (@(posedge aclk) done_p && rx_pcb[5] && !rx_pcb[7]);
	cov_mute:  cover property (@(posedge aclk) $rose(mute_reg));
	cov_abort: cover property (@(posedge aclk) tx_start
		&& tx_pcb == {bpr_pkg::S_TAG, 1'b1, bpr_pkg::S_ABORT});
endmodule : bpr_top

// ---- test/bpr_term_model.sv ----
`timescale 1ns/1ps
module bpr_term_model (
	input  wire logic       aclk,
	output logic            rx_done,
	output logic [7:0]      rx_pcb,
	output logic [7:0]      rx_len,
	output logic            rx_parity_err,
	output logic            rx_lrc_err,
	output logic            rx_sync_lost,
	output logic            bwt_expired,
	input  wire logic       tx_start,
	input  wire logic [7:0] tx_pcb,
	input  wire logic [7:0] tx_len
);
	int         tx_cnt = 0;
	logic [7:0] last_pcb = 8'h00;
	logic [7:0] last_len = 8'h00;

	initial begin
		rx_done = 1'b0;
		rx_pcb = 8'h00;
		rx_len = 8'h00;
		{rx_parity_err, rx_lrc_err, rx_sync_lost} = 3'h0;
		bwt_expired = 1'b0;
	end

	always @(posedge aclk) begin
		if (tx_start === 1'b1) begin
			tx_cnt <= tx_cnt + 1;
			last_pcb <= tx_pcb;
			last_len <= tx_len;
		end
	end

	task automatic blk(input logic [7:0] pcb, input logic [7:0] len,
		input logic [2:0] err);
		rx_pcb <= pcb;
		rx_len <= len;
		{rx_sync_lost, rx_lrc_err, rx_parity_err} <= err;
		rx_done <= 1'b1;
		repeat (4) @(posedge aclk);
		rx_done <= 1'b0;
		// stale header must not look valid once hold is over
		rx_pcb <= ~pcb;
		rx_len <= ~len;
		{rx_sync_lost, rx_lrc_err, rx_parity_err} <= 3'h0;
		@(posedge aclk);
	endtask : blk

	task automatic tmo;
		bwt_expired <= 1'b1;
		repeat (2) @(posedge aclk);
		bwt_expired <= 1'b0;
		@(posedge aclk);
	endtask : tmo
endmodule : bpr_term_model

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready = 1'b0;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready = 1'b0;
	logic        rx_done, rx_parity_err, rx_lrc_err, rx_sync_lost;
	logic        bwt_expired, tx_start;
	logic [7:0]  rx_pcb, rx_len, tx_pcb, tx_len, ln, p1;
	logic [31:0] rd;
	int          n_errors = 0;
	int          checks_done = 0;
	int          seed = 12876;

	always #5 aclk = ~aclk;

	bpr_top bpr_top_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .rx_done(rx_done), .rx_pcb(rx_pcb),
		.rx_len(rx_len), .rx_parity_err(rx_parity_err),
		.rx_lrc_err(rx_lrc_err), .rx_sync_lost(rx_sync_lost),
		.bwt_expired(bwt_expired), .tx_start(tx_start), .tx_pcb(tx_pcb),
		.tx_len(tx_len));

	bpr_term_model bpr_term_model_inst (.aclk(aclk), .rx_done(rx_done),
		.rx_pcb(rx_pcb), .rx_len(rx_len), .rx_parity_err(rx_parity_err),
		.rx_lrc_err(rx_lrc_err), .rx_sync_lost(rx_sync_lost),
		.bwt_expired(bwt_expired), .tx_start(tx_start), .tx_pcb(tx_pcb),
		.tx_len(tx_len));

	function automatic logic [7:0] r_pcb(input logic nr, input logic [3:0] c);
		return {bpr_pkg::R_TAG, nr, c};
	endfunction : r_pcb
	function automatic logic [7:0] i_pcb(input logic ns, input logic m);
		return {1'b0, ns, m, 5'h00};
	endfunction : i_pcb
	function automatic logic [7:0] s_pcb(input logic rsp, input logic [4:0] t);
		return {bpr_pkg::S_TAG, rsp, t};
	endfunction : s_pcb
	function automatic logic [31:0] blkw(input logic [7:0] p, input logic [7:0] l,
		input logic [2:0] e);
		return {13'h0, e, p, l};
	endfunction : blkw
	function automatic logic [31:0] cmdw(input logic [1:0] c, input logic [7:0] l,
		input logic m);
		return {15'h0, m, l, 6'h0, c};
	endfunction : cmdw

	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up

	task automatic fail(input string msg);
		n_errors++;
		$display("[FAIL] %0t %s", $time, msg);
	endtask : fail

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail($sformatf("got %h expected %h", got, exp));
		end
	endtask : chk

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		bit done;
		done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (i = 0; i < 50 && !done; i++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) begin
				done = 1'b1;
				chk({6'h0, s_axi_bresp}, 8'h00);
				s_axi_bready <= 1'b0;
			end
		end
		if (!done) begin
			fail("write timeout");
			wrap_up();
		end
		@(posedge aclk);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
		int i;
		bit done;
		done = 1'b0;
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (i = 0; i < 50 && !done; i++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				done = 1'b1;
				d = s_axi_rdata;
				chk({6'h0, s_axi_rresp}, 8'h00);
				s_axi_rready <= 1'b0;
			end
		end
		if (!done) begin
			fail("read timeout");
			wrap_up();
		end
		@(posedge aclk);
	endtask : axi_rd

	// kind 0 block from far side, 1 waiting time out, 2 host command
	// want: blocks the card must send in reply, 2 means not checked
	task automatic act(input int kind, input logic [31:0] d, input int want);
		int c0;
		int i;
		c0 = bpr_term_model_inst.tx_cnt;
		if (kind == 0) bpr_term_model_inst.blk(d[15:8], d[7:0], d[18:16]);
		else if (kind == 1) bpr_term_model_inst.tmo();
		else axi_wr(bpr_pkg::OFF_CMD, d);
		for (i = 0; i < 20 && bpr_term_model_inst.tx_cnt == c0; i++)
			@(posedge aclk);
		repeat (3) @(posedge aclk);
		if (want != 2) begin
			checks_done++;
			if (bpr_term_model_inst.tx_cnt - c0 != want) fail("reply count");
		end
	endtask : act

	task automatic do_reset;
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		chk({7'h0, tx_start}, 8'h00);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask : do_reset

	initial begin
		do_reset();
		axi_rd(bpr_pkg::OFF_IFS, rd);
		chk(rd[15:8], bpr_pkg::IFS_RESET);
		chk(rd[7:0], bpr_pkg::IFS_RESET);
		axi_rd(8'h40, rd);
		chk({7'h0, |rd}, 8'h00);
		axi_wr(bpr_pkg::OFF_IFS, 32'h00002010);
		axi_rd(bpr_pkg::OFF_IFS, rd);
		chk(rd[7:0], 8'h10);
		act(0, blkw(i_pcb(0, 0), 8'h05, 3'h1), 1);
		chk(bpr_term_model_inst.last_pcb, r_pcb(0, bpr_pkg::R_EDC));
		act(0, blkw(i_pcb(0, 0), 8'h11, 3'h0), 1);
		chk(bpr_term_model_inst.last_pcb, r_pcb(0, bpr_pkg::R_OTHER));
		act(0, blkw(i_pcb(0, 1), 8'h10, 3'h0), 1);
		chk(bpr_term_model_inst.last_pcb, r_pcb(1, bpr_pkg::R_OK));
		act(0, blkw(i_pcb(1, 1), 8'h10, 3'h0), 1);
		chk(bpr_term_model_inst.last_pcb, r_pcb(0, bpr_pkg::R_OK));
		act(0, blkw(8'hA0, 8'h00, 3'h0), 1);
		chk(bpr_term_model_inst.last_pcb, r_pcb(0, bpr_pkg::R_OK));
		act(0, blkw(s_pcb(0, bpr_pkg::S_ABORT), 8'h00, 3'h0), 1);
		chk(bpr_term_model_inst.last_pcb, s_pcb(1, bpr_pkg::S_ABORT));
		ln = 8'($unsigned($random(seed)) % 17);
		act(0, blkw(i_pcb(0, 0), ln, 3'h0), 2);
		act(2, cmdw(bpr_pkg::CMD_IBLK, 8'h30, 1), 1);
		chk(bpr_term_model_inst.last_pcb, i_pcb(0, 1));
		chk(bpr_term_model_inst.last_len, bpr_pkg::IFS_RESET);
		act(0, blkw(r_pcb(1, bpr_pkg::R_OK), 8'h00, 3'h0), 2);
		ln = 8'(1 + $unsigned($random(seed)) % 32);
		act(2, cmdw(bpr_pkg::CMD_IBLK, ln, 0), 1);
		chk(bpr_term_model_inst.last_pcb, i_pcb(1, 0));
		chk(bpr_term_model_inst.last_len, ln);
		act(1, 32'h0, 1);
		chk(bpr_term_model_inst.last_pcb >> 4, r_pcb(1, 4'h0) >> 4);
		p1 = bpr_term_model_inst.last_pcb;
		act(1, 32'h0, 1);
		chk(bpr_term_model_inst.last_pcb, p1);
		act(1, 32'h0, 0);
		axi_rd(bpr_pkg::OFF_STATUS, rd);
		chk({7'h0, rd[6]}, 8'h01);
		act(2, cmdw(bpr_pkg::CMD_IBLK, 8'h04, 0), 0);
		do_reset();
		act(2, cmdw(bpr_pkg::CMD_IFSREQ, 8'h01, 0), 1);
		chk(bpr_term_model_inst.last_pcb, s_pcb(0, bpr_pkg::S_IFS));
		act(0, blkw(8'h00, 8'h00, 3'h2), 1);
		chk(bpr_term_model_inst.last_pcb, s_pcb(0, bpr_pkg::S_IFS));
		act(0, blkw(8'h00, 8'h00, 3'h4), 0);
		act(2, cmdw(bpr_pkg::CMD_ABORT, 8'h00, 0), 1);
		chk(bpr_term_model_inst.last_pcb, s_pcb(0, bpr_pkg::S_ABORT));
		act(0, blkw(r_pcb(0, bpr_pkg::R_OK), 8'h00, 3'h0), 1);
		chk(bpr_term_model_inst.last_pcb, s_pcb(0, bpr_pkg::S_ABORT));
		act(0, blkw(s_pcb(1, bpr_pkg::S_ABORT), 8'h00, 3'h0), 2);
		act(0, blkw(s_pcb(0, bpr_pkg::S_RESYNCH), 8'h00, 3'h0), 1);
		chk(bpr_term_model_inst.last_pcb, s_pcb(1, bpr_pkg::S_RESYNCH));
		act(0, blkw(8'h00, 8'h00, 3'h1), 1);
		chk(bpr_term_model_inst.last_pcb >> 5, {5'h0, bpr_pkg::R_TAG});
		wrap_up();
	end
endmodule : testbench
